/* core/crad_pkg.sv */
// Constants, types and state layout for the calibration register access decoder.
// Assumes a single 20 MHz clock and that the serial port pins are synchronous to it.
package crad_pkg;

  localparam int          DATA_W      = 32;
  localparam int          NUM_CH      = 4;
  localparam int          NUM_TYPE    = 3;
  // Command byte field positions
  localparam int          BIT_CMD     = 7;
  localparam int          BIT_ARRAY   = 6;
  localparam int          BIT_CS_HI   = 5;
  localparam int          BIT_CS_LO   = 4;
  localparam int          BIT_RW      = 3;
  // Register type select codes in bits 2..0
  localparam logic [2:0]  CODE_OFFSET = 3'h1;
  localparam logic [2:0]  CODE_GAIN   = 3'h2;
  localparam logic [2:0]  CODE_SETUP  = 3'h5;
  // Internal register bank indices
  localparam logic [1:0]  TYPE_OFFSET = 2'h0;
  localparam logic [1:0]  TYPE_GAIN   = 2'h1;
  localparam logic [1:0]  TYPE_SETUP  = 2'h2;
  // Bit counters and channel bounds
  localparam logic [4:0]  CMD_LAST    = 5'h07;
  localparam logic [4:0]  DATA_LAST   = 5'h1F;
  localparam logic [1:0]  LAST_CH_4   = 2'h3;
  localparam logic [1:0]  LAST_CH_2   = 2'h1;
  // Reset contents of the bank
  localparam logic [DATA_W-1:0] OFFSET_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] GAIN_RST   = 32'h0100_0000;
  localparam logic [DATA_W-1:0] SETUP_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_DATA = 3'b010,
    ST_SKIP = 3'b100
  } crad_state_t;

  typedef struct packed {
    logic       valid;
    logic       array_access_flag;
    logic       read;
    logic [1:0] register_type_select;
    logic [1:0] chan;
  } crad_cmd_t;

  typedef struct packed {
    logic              strobe;
    logic [1:0]        register_type_select;
    logic [1:0]        chan;
    logic [DATA_W-1:0] data;
  } crad_wr_t;

  typedef logic [NUM_TYPE-1:0][NUM_CH-1:0][DATA_W-1:0] crad_bank_t;

  typedef struct packed {
    crad_state_t       state;
    crad_cmd_t         cmd;
    logic [6:0]        cmd_sr;
    logic [4:0]        bit_cnt;
    logic [1:0]        word;
    logic [DATA_W-1:0] sr;
    logic              sclk_q;
    logic              sdo;
    logic              busy;
    logic              unsupported;
    crad_wr_t          wr;
    crad_bank_t        bank;
  } crad_q_t;

endpackage : crad_pkg

/* core/crad_cmd_decode.sv */
// Combinational decoder from a serial command byte to a register access request.
// Assumes the caller registers the result; no state lives here.
`timescale 1ns/1ns
module crad_cmd_decode (
  input  wire logic [7:0]          cmd_byte_i,
  input  wire logic                four_channel_i,
  output crad_pkg::crad_cmd_t      cmd_o
);
  import crad_pkg::*;

  logic [2:0] type_code;
  logic [1:0] chan;
  logic       arr;
  logic       type_ok;
  logic       chan_ok;

  // Field extraction and validity
  always_comb begin
    type_code = cmd_byte_i[2:0];
    chan      = cmd_byte_i[BIT_CS_HI:BIT_CS_LO];
    arr       = cmd_byte_i[BIT_ARRAY];
    type_ok   = (type_code == CODE_OFFSET) || (type_code == CODE_GAIN)
                || (type_code == CODE_SETUP);
    // Upper offset and gain slots exist only on the four-channel variant
    chan_ok = arr ? (chan == 2'h0)
                  : (four_channel_i || !chan[1] || type_code == CODE_SETUP);
    cmd_o.valid                = !cmd_byte_i[BIT_CMD] && type_ok && chan_ok;
    cmd_o.array_access_flag    = arr;
    cmd_o.read                 = cmd_byte_i[BIT_RW];
    cmd_o.chan                 = arr ? 2'h0 : chan;
    case (type_code)
      CODE_GAIN:  cmd_o.register_type_select = TYPE_GAIN;
      CODE_SETUP: cmd_o.register_type_select = TYPE_SETUP;
      default:   cmd_o.register_type_select = TYPE_OFFSET;
    endcase
  end

endmodule : crad_cmd_decode

/* core/crad_core.sv */
// Serial port slave that decodes register access commands and moves calibration data.
// Assumes all pins are synchronous to clock_i and that serial clock idles low between bits.
`timescale 1ns/1ns
module crad_core (
  input  wire logic                clock_i,
  input  wire logic                arst_n_i,
  input  wire logic                ce_i,
  input  wire logic                cs_n_i,
  input  wire logic                sclk_i,
  input  wire logic                sdi_i,
  input  wire logic                four_channel_i,
  output logic                     sdo_o,
  output logic                     busy_o,
  output logic                     unsupported_o,
  output crad_pkg::crad_wr_t       wr_o
);
  import crad_pkg::*;

  crad_q_t           q;
  crad_q_t           next_q;
  crad_cmd_t         dec;
  logic [7:0]        cmd_byte;
  logic              rise;
  logic              fall;
  logic              cmd_end;
  logic              word_end;
  logic [1:0]        last_word;

  // Bank lookup shared by command end and word end
  function automatic logic [DATA_W-1:0] pick(input crad_bank_t b, input logic [1:0] t,
                                            input logic [1:0] idx);
    pick = b[t][idx];
  endfunction : pick

  // Byte as it stands after the current rising edge, MSB arrived first
  assign cmd_byte = {q.cmd_sr, sdi_i};

  crad_cmd_decode u_dec (
    .cmd_byte_i     (cmd_byte),
    .four_channel_i (four_channel_i),
    .cmd_o          (dec)
  );

  // Edge detection on the sampled serial clock
  always_comb begin
    rise      = sclk_i && !q.sclk_q;
    fall      = !sclk_i && q.sclk_q;
    cmd_end   = !cs_n_i && rise && (q.state == ST_CMD) && (q.bit_cnt == CMD_LAST);
    word_end  = !cs_n_i && rise && (q.state == ST_DATA) && (q.bit_cnt == DATA_LAST);
    // Setup registers exist four deep on every variant
    if (!q.cmd.array_access_flag) begin
      last_word = q.cmd.chan;
    end else if (four_channel_i || q.cmd.register_type_select == TYPE_SETUP) begin
      last_word = LAST_CH_4;
    end else begin
      last_word = LAST_CH_2;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    next_q           = q;
    next_q.sclk_q    = sclk_i;
    next_q.wr.strobe = 1'b0;
    if (cs_n_i) begin
      // Deselect aborts any frame; a half word written is dropped, not committed
      next_q.state   = ST_CMD;
      next_q.bit_cnt = 5'h00;
      next_q.word    = 2'h0;
      next_q.busy    = 1'b0;
      next_q.sdo     = 1'b0;
    end else begin
      case (q.state)
        ST_CMD: begin
          if (rise) begin
            next_q.cmd_sr  = cmd_byte[6:0];
            next_q.bit_cnt = q.bit_cnt + 5'h01;
            if (cmd_end) begin
              next_q.bit_cnt     = 5'h00;
              next_q.unsupported = !dec.valid;
              if (dec.valid) begin
                // Data phase starts on the very next serial clock
                next_q.state = ST_DATA;
                next_q.cmd   = dec;
                next_q.word  = dec.chan;
                next_q.busy  = 1'b1;
                next_q.sr    = pick(q.bank, dec.register_type_select, dec.chan);
              end else begin
                next_q.state = ST_SKIP;
              end
            end
          end
        end
        ST_DATA: begin
          if (rise) begin
            next_q.bit_cnt = q.bit_cnt + 5'h01;
            if (!q.cmd.read) begin
              next_q.sr = {q.sr[DATA_W-2:0], sdi_i};
            end
            if (word_end) begin
              next_q.bit_cnt = 5'h00;
              if (!q.cmd.read) begin
                // Commit the completed word and announce it
                next_q.bank[q.cmd.register_type_select][q.word] = {q.sr[DATA_W-2:0], sdi_i};
                next_q.wr.strobe               = 1'b1;
                next_q.wr.register_type_select = q.cmd.register_type_select;
                next_q.wr.chan                 = q.word;
                next_q.wr.data                 = {q.sr[DATA_W-2:0], sdi_i};
              end
              if (q.word == last_word) begin
                next_q.state = ST_SKIP;
                next_q.busy  = 1'b0;
              end else begin
                next_q.word = q.word + 2'h1;
                next_q.sr   = pick(q.bank, q.cmd.register_type_select, q.word + 2'h1);
              end
            end
          end else if (fall && q.cmd.read) begin
            // Present the next bit on the falling edge so it is stable for the rising one
            next_q.sdo = q.sr[DATA_W-1];
            next_q.sr  = {q.sr[DATA_W-2:0], 1'b0};
          end
        end
        ST_SKIP: begin
          // Extra clocks after the frame, or after a bad command, are ignored
          next_q.sdo = 1'b0;
        end
        default: begin
          next_q.state = ST_CMD;
        end
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q       <= '0;
      q.state <= ST_CMD;
      for (int c = 0; c < NUM_CH; c++) begin
        q.bank[TYPE_OFFSET][c] <= OFFSET_RST;
        q.bank[TYPE_GAIN][c]   <= GAIN_RST;
        q.bank[TYPE_SETUP][c]  <= SETUP_RST;
      end
    end else if (ce_i) begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign sdo_o         = q.sdo;
  assign busy_o        = q.busy;
  assign unsupported_o = q.unsupported;
  assign wr_o          = q.wr;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_cmd_end;
    ce_i && cmd_end;
  endsequence

  sequence s_byte(logic [7:0] pat, logic [7:0] msk);
    s_cmd_end ##0 ((cmd_byte & msk) == pat);
  endsequence

  AST_ARRAY_OFFSET: assert property (
    s_byte(8'h41, 8'hF7) |=> q.state == ST_DATA && q.cmd.array_access_flag
      && q.cmd.register_type_select == TYPE_OFFSET && q.word == 2'h0)
    else $error("offset array command not decoded");

  AST_ARRAY_GAIN: assert property (
    s_byte(8'h42, 8'hF7) |=> q.state == ST_DATA && q.cmd.array_access_flag
      && q.cmd.register_type_select == TYPE_GAIN)
    else $error("gain array command not decoded");

  AST_ARRAY_SETUP: assert property (
    s_byte(8'h45, 8'hF7) |=> q.state == ST_DATA && q.cmd.array_access_flag
      && q.cmd.register_type_select == TYPE_SETUP)
    else $error("setup array command not decoded");

  AST_DIRECTION: assert property (
    s_cmd_end ##0 dec.valid |=> q.cmd.read == $past(cmd_byte[BIT_RW]))
    else $error("direction bit not taken");

  AST_ONE_OFFSET: assert property (
    s_byte(8'h01, 8'hC7) ##0 (four_channel_i || !cmd_byte[BIT_CS_HI])
      |=> q.state == ST_DATA && !q.cmd.array_access_flag
      && q.word == $past(cmd_byte[BIT_CS_HI:BIT_CS_LO]))
    else $error("individual offset channel wrong");

  AST_TWO_CH_LIMIT: assert property (
    s_byte(8'h21, 8'hE7) ##0 !four_channel_i |=> q.state == ST_SKIP && q.unsupported)
    else $error("upper offset slot accepted on two-channel part");

  AST_ONE_GAIN: assert property (
    s_byte(8'h02, 8'hC7) ##0 four_channel_i |=> q.state == ST_DATA
      && q.cmd.register_type_select == TYPE_GAIN && !q.cmd.array_access_flag)
    else $error("individual gain command not decoded");

  AST_WRITE_ONLY: assert property (
    $rose(q.wr.strobe) |-> !q.cmd.read && q.wr.chan == $past(q.word)
      && q.bank[q.wr.register_type_select][q.wr.chan] == q.wr.data)
    else $error("write strobe on a read or wrong slot");

  AST_ASCEND: assert property (
    ce_i && word_end && q.word != last_word |=> q.word == $past(q.word) + 2'h1)
    else $error("array channel order broken");

  AST_MSB_OUT: assert property (
    ce_i && !cs_n_i && fall && q.state == ST_DATA && q.cmd.read
      |=> sdo_o == $past(q.sr[DATA_W-1]))
    else $error("serial output not MSB first");

  // First bit of every read word is the stored word's top bit, not a shifted copy
  AST_FIRST_BIT: assert property (
    ce_i && !cs_n_i && fall && q.state == ST_DATA && q.cmd.read && q.bit_cnt == 5'h00
      |=> sdo_o == $past(q.bank[q.cmd.register_type_select][q.word][DATA_W-1]))
    else $error("read word does not start with its top bit");

  AST_DATA_NEXT: assert property (
    s_cmd_end ##0 dec.valid |=> busy_o && q.bit_cnt == 5'h00 && !unsupported_o)
    else $error("data phase does not follow the command byte");

  AST_CMD_BIT_HIGH: assert property (
    s_cmd_end ##0 cmd_byte[BIT_CMD] |=> q.state == ST_SKIP && unsupported_o && !busy_o)
    else $error("command with top bit set was accepted");

  AST_STROBE_PULSE: assert property (
    ce_i && q.wr.strobe |=> !q.wr.strobe)
    else $error("write strobe longer than one cycle");

endmodule : crad_core

/* testbench/crad_host_model.sv */
// Host side model: serial port master that frames a command byte and data words.
// Assumes sdo_i is registered to clock_i; each bit lasts 5 clocks and sclk idles low.
`timescale 1ns/1ns
module crad_host_model (
  input  wire logic clock_i,
  input  wire logic sdo_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  // Idle pins at time zero
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end

  // One frame; read data is sampled just before each rise, after the fall has settled
  task automatic xfer(input logic [7:0] cmd, input int nw,
                      input logic [3:0][31:0] wd, output logic [3:0][31:0] rd);
    int k;
    rd = '0;
    @(posedge clock_i);
    cs_n_o <= 1'b0;
    for (int b = 0; b < 8 + 32 * nw; b++) begin
      k = b - 8;
      @(posedge clock_i);
      sclk_o <= 1'b0;
      sdi_o  <= (b < 8) ? cmd[7 - b] : wd[k / 32][31 - k % 32];
      repeat (3) @(posedge clock_i);
      if (b >= 8) rd[k / 32][31 - k % 32] = sdo_i;
      sclk_o <= 1'b1;
      @(posedge clock_i);
    end
    @(posedge clock_i);
    sclk_o <= 1'b0;
    cs_n_o <= 1'b1;
    sdi_o  <= ~sdi_o; // Released line does not keep its last value
    repeat (3) @(posedge clock_i);
  endtask : xfer
endmodule : crad_host_model

/* testbench/tb_crad_core.sv */
// Self-checking bench for the calibration register access decoder core.
// Assumes the host model drives the serial pins and one 20 MHz clock.
`timescale 1ns/1ns
module tb_crad_core;
  import crad_pkg::*;
  logic             clock_i  = 1'b0;
  logic             arst_n_i = 1'b0;
  logic             four_ch  = 1'b1;
  logic             ce       = 1'b1;
  logic             cs_n, sclk, sdi, sdo, busy, unsup;
  crad_wr_t         wr;
  int               bad_count  = 0;
  int               n_compared = 0;
  int               cyc        = 0;
  int               busy_cyc   = 0;
  logic [31:0]      seed       = 32'hF8BE2419;
  logic [35:0]      exp_wr[$];
  logic [3:0][31:0] wd, rd;
  logic [2:0][3:0][31:0] mdl;
  logic [2:0]       codes[3] = '{CODE_OFFSET, CODE_GAIN, CODE_SETUP};
  logic [7:0]       bad[7]   = '{8'h21, 8'h32, 8'h81, 8'h51, 8'h00, 8'h03, 8'h46};

  crad_core i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce), .cs_n_i(cs_n),
    .sclk_i(sclk), .sdi_i(sdi), .four_channel_i(four_ch), .sdo_o(sdo), .busy_o(busy),
    .unsupported_o(unsup), .wr_o(wr));
  crad_host_model i_host (.clock_i(clock_i), .sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi));

  always #25 clock_i = ~clock_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr

  // Compare type, channel and data of one word
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic print_verdict;
    $display("Counts: compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Committed writes are checked off mid-cycle, clear of the launching edge
  always @(negedge clock_i) begin
    if (wr.strobe === 1'b1)
      cmp({wr.register_type_select, wr.chan, wr.data},
          exp_wr.size() != 0 ? exp_wr.pop_front() : 36'hX, "write");
  end

  // Busy length per frame, counted mid-cycle clear of the launching edge
  always @(negedge clock_i) begin
    if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
  end

  // Hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      $display("ERROR t=%0t timeout", $time);
      print_verdict();
    end
  end

  // One command frame; ok low means the byte must be refused
  task automatic access(input logic [7:0] cmd, input int nw, input bit ok);
    logic [1:0] t;
    logic [1:0] ch;
    int         b0;
    t = (cmd[2:0] == CODE_OFFSET) ? TYPE_OFFSET
      : (cmd[2:0] == CODE_GAIN) ? TYPE_GAIN : TYPE_SETUP;
    for (int i = 0; i < nw; i++) begin
      ch = cmd[6] ? 2'(i) : cmd[5:4];
      wd[i] = seed;
      seed = lfsr(seed);
      if (ok && !cmd[3]) begin
        exp_wr.push_back({t, ch, wd[i]});
        mdl[t][ch] = wd[i];
      end
    end
    b0 = busy_cyc;
    i_host.xfer(cmd, nw, wd, rd);
    for (int i = 0; i < nw; i++) begin
      ch = cmd[6] ? 2'(i) : cmd[5:4];
      if (ok && cmd[3]) cmp({t, ch, rd[i]}, {t, ch, mdl[t][ch]}, "read");
    end
    cmp({35'h0, unsup}, {35'h0, !ok}, "refusal flag");
    // Busy spans every data bit: 32 bits a word, 5 clocks a host bit
    cmp(36'(busy_cyc - b0), ok ? 36'(160 * nw) : 36'h0, "busy cycles");
  endtask : access

  initial begin
    mdl = '0;
    for (int i = 0; i < 4; i++) mdl[TYPE_GAIN][i] = GAIN_RST;
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    foreach (codes[j]) access({5'h01, codes[j]}, 1, 1);
    $display("test reset contents done");
    foreach (codes[j])
      for (int c = 0; c < 4; c++) begin
        access({2'b00, 2'(c), 1'b0, codes[j]}, 1, 1);
        access({2'b00, 2'(c), 1'b1, codes[j]}, 1, 1);
      end
    $display("test single registers done");
    foreach (codes[j]) begin
      access({5'h08, codes[j]}, 4, 1);
      access({5'h09, codes[j]}, 4, 1);
      for (int c = 0; c < 4; c++) access({2'b00, 2'(c), 1'b1, codes[j]}, 1, 1);
    end
    $display("test arrays done");
    @(posedge clock_i);
    four_ch <= 1'b0;
    foreach (bad[j]) access(bad[j], 1, 0);
    access(8'h41, 2, 1);
    access(8'h49, 2, 1);
    access(8'h25, 1, 1);
    $display("test two-channel part done");
    // A frame sent while the clock enable is low must leave every register alone
    wd[0] = ~mdl[TYPE_SETUP][0];
    ce <= 1'b0;
    i_host.xfer(8'h05, 1, wd, rd);
    ce <= 1'b1;
    access(8'h0D, 1, 1);
    $display("test clock enable freeze done");
    repeat (4) @(posedge clock_i);
    cmp(36'(exp_wr.size()), 36'h0, "writes missing");
    print_verdict();
  end
endmodule : tb_crad_core
